//--- src/mg_pkg.sv
// constants shared by the magnetometer register bank and its testbench
// assumes a single 40 MHz core clock and an active low asynchronous reset
package mg_pkg;
  localparam real CLK_PERIOD_NS = 25.0;

  // register offsets on the serial interface
  localparam logic [6:0] ADDR_CHIP_ID = 7'h40;
  localparam logic [6:0] ADDR_Z_LOW = 7'h46;
  localparam logic [6:0] ADDR_Z_HIGH = 7'h47;
  localparam logic [6:0] ADDR_HALL_LOW = 7'h48;
  localparam logic [6:0] ADDR_HALL_HIGH = 7'h49;
  localparam logic [6:0] ADDR_IRQ_FLAGS = 7'h4a;
  localparam logic [6:0] ADDR_POWER = 7'h4b;
  localparam logic [6:0] ADDR_MODE = 7'h4c;

  // power_reset_ctrl field positions
  localparam int PWR_ON_BIT = 0;
  localparam int SRST_LO_BIT = 1;
  localparam int THREE_WIRE_BIT = 2;
  localparam int SRST_HI_BIT = 7;

  // mode_rate_selftest_ctrl field positions
  localparam int MODE_SELFTEST_BIT = 0;
  localparam int MODE_OP_LSB = 1;
  localparam int MODE_RATE_LSB = 3;
  localparam int MODE_ADV_LSB = 6;

  // values after reset, and the op mode codes
  localparam logic [7:0] MODE_RST = 8'h06;
  localparam logic Z_SELFTEST_RST = 1'b1;
  localparam logic [1:0] OPMODE_NORMAL = 2'h0;
  localparam logic [1:0] OPMODE_FORCED = 2'h1;
  localparam logic [1:0] OPMODE_SLEEP = 2'h3;
  localparam logic [2:0] RATE_10HZ = 3'h0;

  // soft reset run length in core clock cycles
  localparam logic [2:0] SRST_CYCLES = 3'h4;

  typedef enum logic {
    SR_IDLE = 1'b0,
    SR_RUN = 1'b1
  } mg_sr_state_t;

  // serial frame phase: address byte, then write or read data bytes
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_WDATA = 2'b01,
    PH_RDATA = 2'b11
  } mg_phase_t;
endpackage

//--- src/mg_pins_if.sv
// synchronised serial pins passed from the synchroniser to the register bank
// assumes all members are already on the core clock
`timescale 1ns/1ps
interface mg_pins_if;
  logic csb;
  logic sck;
  logic sdi;
  modport sync (output csb, output sck, output sdi);
  modport core (input csb, input sck, input sdi);
endinterface

//--- src/mg_pin_sync.sv
// two-flop synchroniser for the serial interface pins
// assumes the pins are asynchronous to the core clock
`timescale 1ns/1ps
module mg_pin_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic csb_raw,
  input wire logic sck_raw,
  input wire logic sdi_raw,
  mg_pins_if.sync pins
);
  // csb resets high so no frame appears to start during reset
  localparam logic [2:0] SYNC_RST = 3'h4;
  logic [2:0] meta_ff;
  logic [2:0] sync_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
    end else begin
      meta_ff <= {csb_raw, sck_raw, sdi_raw};
      sync_ff <= meta_ff;
    end
  end

  assign pins.csb = sync_ff[2];
  assign pins.sck = sync_ff[1];
  assign pins.sdi = sync_ff[0];
endmodule

//--- src/mg_regbank.sv
// register bank of the three-axis magnetometer: data, status, power and mode registers
// assumes sample and event inputs come from sensor logic on MCLK; serial pins are asynchronous
//
// What this block does
// - z sample bits 6..0 appear in z low register bits 7..1.
// - z low register bit 0 is the z self-test flag, one by default.
// - z sample bits 14..7 appear in z high register bits 7..0.
// - hall sample bits 5..0 in hall low bits 7..2; bit 1 reads zero.
// - hall sample bits 13..6 appear in hall high register bits 7..0.
// - hall low register bit 0 shows the sample-ready status.
// - irq flags: overrun, overflow, high z/y/x, low z/y/x from bit 7 down.
// - power register stays accessible in suspend; others read zero there.
// - soft reset only when a write sets both bit 7 and bit 1.
// - soft reset restores defaults except power register; not a full power-on.
// - soft reset always ends in sleep mode.
// - soft reset requested in suspend is ignored; device stays suspended.
// - both soft reset trigger bits clear themselves when reset finishes.
// - suspend then sleep transition runs the full power-on reset.
// - power register bit 2 picks three-wire serial when one, four-wire when zero.
// - power bit one leaves suspend, zero returns to suspend; bits 6..3 read zero.
// - mode register: adv self-test 7:6, rate 5:3, op mode 2:1, self-test 0.
// - rate codes 0..7 give 10, 2, 6, 8, 15, 20, 25, 30 Hz.
// - op mode 00 normal, 01 forced, 11 sleep.
// - latched interrupt output holds until irq flags register is read.
// - identification register reads only while the power bit is one.
`timescale 1ns/1ps
module mg_regbank
  import mg_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5a // arbitrary identification value
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic CSB,
  input wire logic SCK,
  input wire logic SDI,
  output logic SDO_O,
  output logic SDO_OE,
  output logic SDX_O,
  output logic SDX_OE,
  input wire logic [14:0] Z_SAMPLE,
  input wire logic Z_ST_RESULT,
  input wire logic [13:0] HALL_SAMPLE,
  input wire logic SAMPLE_VALID,
  input wire logic [7:0] IRQ_EVENTS,
  input wire logic INT_LATCH,
  output logic POWER_ON,
  output logic THREE_WIRE,
  output logic [1:0] OP_MODE,
  output logic [2:0] OUTPUT_RATE,
  output logic [1:0] ADV_SELFTEST,
  output logic SELFTEST_TRIG,
  output logic SOFT_RESET_DONE,
  output logic POR_PULSE,
  output logic INT_OUT
);
  mg_pins_if pins ();

  mg_pin_sync u_sync (
    .clk(MCLK),
    .rst_b(RST_B),
    .csb_raw(CSB),
    .sck_raw(SCK),
    .sdi_raw(SDI),
    .pins(pins.sync)
  );

  // serial frame engine
  logic sck_d_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] rx_ff;
  logic [6:0] addr_ff;
  mg_phase_t phase_ff;
  logic [7:0] tx_ff;
  logic out_ff;
  logic active;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [6:0] rd_addr;
  logic rd_strobe;
  logic [7:0] rd_byte;
  logic wr_en;
  logic [6:0] nxt_addr;

  // register state
  logic power_ff;
  logic three_wire_ff;
  logic srst_hi_ff;
  logic srst_lo_ff;
  logic [7:0] mode_ff;
  logic [14:0] z_ff;
  logic zst_ff;
  logic [13:0] hall_ff;
  logic sample_ready_ff;
  logic [7:0] irq_ff;
  logic [7:0] nxt_irq;
  logic int_ff;
  mg_sr_state_t sr_state_ff;
  logic [2:0] sr_cnt_ff;
  logic sr_done_ff;
  logic por_ff;
  logic wr_power;
  logic wr_other;
  logic sr_start;
  logic sr_done;
  logic por_go;
  logic clr_all;
  logic irq_read;
  logic pend_irq_ff, pend_rdy_ff;

  assign active = ~pins.csb;
  assign sck_rise = active & pins.sck & ~sck_d_ff;
  assign sck_fall = active & ~pins.sck & sck_d_ff;
  assign byte_done = sck_rise & (bit_cnt_ff == 3'h7);
  assign rx_byte = {rx_ff, pins.sdi};
  assign nxt_addr = addr_ff + 7'h01;
  assign rd_addr = (phase_ff == PH_ADDR) ? rx_byte[6:0] : nxt_addr;
  assign rd_strobe = byte_done & ((phase_ff == PH_ADDR) ? rx_byte[7] : (phase_ff == PH_RDATA));
  assign wr_en = byte_done & (phase_ff == PH_WDATA);

  // everything but the power register is closed in suspend
  function automatic logic [7:0] reg_value(input logic [6:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (power_ff || a == ADDR_POWER) begin
      unique case (a)
        ADDR_CHIP_ID: v = CHIP_ID;
        ADDR_Z_LOW: v = {z_ff[6:0], zst_ff};
        ADDR_Z_HIGH: v = z_ff[14:7];
        ADDR_HALL_LOW: v = {hall_ff[5:0], 1'b0, sample_ready_ff};
        ADDR_HALL_HIGH: v = hall_ff[13:6];
        ADDR_IRQ_FLAGS: v = irq_ff;
        ADDR_POWER: v = {srst_hi_ff, 4'h0, three_wire_ff, srst_lo_ff, power_ff};
        ADDR_MODE: v = mode_ff;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  assign rd_byte = reg_value(rd_addr);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      sck_d_ff <= 1'b0;
    end else begin
      sck_d_ff <= pins.sck;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      bit_cnt_ff <= 3'h0;
      rx_ff <= 7'h00;
      phase_ff <= PH_ADDR;
      addr_ff <= 7'h00;
    end else if (!active) begin
      bit_cnt_ff <= 3'h0;
      phase_ff <= PH_ADDR;
    end else if (sck_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
      rx_ff <= rx_byte[6:0];
      if (byte_done) begin
        if (phase_ff == PH_ADDR) begin
          addr_ff <= rx_byte[6:0];
          phase_ff <= rx_byte[7] ? PH_RDATA : PH_WDATA;
        end else begin
          addr_ff <= nxt_addr;
        end
      end
    end
  end

  // msb first on falling edges; read side effects wait for the host's first sampled bit, not the prefetch
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_ff <= 8'h00;
      out_ff <= 1'b0;
      pend_irq_ff <= 1'b0;
      pend_rdy_ff <= 1'b0;
    end else if (rd_strobe) begin
      tx_ff <= rd_byte;
      pend_irq_ff <= power_ff & (rd_addr == ADDR_IRQ_FLAGS);
      pend_rdy_ff <= power_ff & (rd_addr == ADDR_HALL_HIGH);
    end else if (sck_fall && phase_ff == PH_RDATA) begin
      out_ff <= tx_ff[7];
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  assign SDO_O = out_ff;
  assign SDX_O = out_ff;
  assign SDO_OE = active & (phase_ff == PH_RDATA) & ~three_wire_ff;
  assign SDX_OE = active & (phase_ff == PH_RDATA) & three_wire_ff;

  // write decode: only the power register is writable in suspend
  assign wr_power = wr_en & (addr_ff == ADDR_POWER);
  assign wr_other = wr_en & power_ff;
  assign sr_start = wr_power & rx_byte[SRST_HI_BIT] & rx_byte[SRST_LO_BIT]
                    & rx_byte[PWR_ON_BIT] & power_ff & (sr_state_ff == SR_IDLE);
  assign sr_done = (sr_state_ff == SR_RUN) & (sr_cnt_ff == SRST_CYCLES - 3'h1);
  assign por_go = wr_power & ~power_ff & rx_byte[PWR_ON_BIT];
  assign clr_all = sr_done | por_go;
  assign irq_read = pend_irq_ff & sck_rise & (phase_ff == PH_RDATA) & (bit_cnt_ff == 3'h0);

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      sr_state_ff <= SR_IDLE;
      sr_cnt_ff <= 3'h0;
      sr_done_ff <= 1'b0;
      por_ff <= 1'b0;
    end else begin
      sr_done_ff <= sr_done;
      por_ff <= por_go;
      unique case (sr_state_ff)
        SR_IDLE: begin
          sr_cnt_ff <= 3'h0;
          if (sr_start) begin
            sr_state_ff <= SR_RUN;
          end
        end
        SR_RUN: begin
          sr_cnt_ff <= sr_cnt_ff + 3'h1;
          if (sr_done) begin
            sr_state_ff <= SR_IDLE;
          end
        end
      endcase
    end
  end

  // power register survives soft reset; trigger bits are dropped in suspend
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      power_ff <= 1'b0;
      three_wire_ff <= 1'b0;
      srst_hi_ff <= 1'b0;
      srst_lo_ff <= 1'b0;
    end else if (wr_power) begin
      power_ff <= rx_byte[PWR_ON_BIT];
      three_wire_ff <= rx_byte[THREE_WIRE_BIT];
      srst_hi_ff <= rx_byte[SRST_HI_BIT] & power_ff & rx_byte[PWR_ON_BIT];
      srst_lo_ff <= rx_byte[SRST_LO_BIT] & power_ff & rx_byte[PWR_ON_BIT];
    end else if (sr_done) begin
      srst_hi_ff <= 1'b0;
      srst_lo_ff <= 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_ff <= MODE_RST;
    end else if (clr_all) begin
      mode_ff <= MODE_RST;
    end else if (wr_other && addr_ff == ADDR_MODE) begin
      mode_ff <= rx_byte;
    end
  end

  // sample registers only load from the sensor side, never from the host
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      z_ff <= 15'h0000;
      zst_ff <= Z_SELFTEST_RST;
      hall_ff <= 14'h0000;
    end else if (clr_all) begin
      z_ff <= 15'h0000;
      zst_ff <= Z_SELFTEST_RST;
      hall_ff <= 14'h0000;
    end else if (SAMPLE_VALID && power_ff) begin
      z_ff <= Z_SAMPLE;
      zst_ff <= Z_ST_RESULT;
      hall_ff <= HALL_SAMPLE;
    end
  end

  // ready is cleared by reading the last data byte; a new sample wins
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      sample_ready_ff <= 1'b0;
    end else if (clr_all) begin
      sample_ready_ff <= 1'b0;
    end else if (SAMPLE_VALID && power_ff) begin
      sample_ready_ff <= 1'b1;
    end else if (pend_rdy_ff && sck_rise && phase_ff == PH_RDATA && bit_cnt_ff == 3'h0) begin
      sample_ready_ff <= 1'b0;
    end
  end

  // in latched mode a read clears only the flags the host saw; an event in that cycle stays set
  always_comb begin
    if (INT_LATCH) begin
      nxt_irq = (irq_ff & ~({8{irq_read}} & {out_ff, tx_ff[7:1]})) | IRQ_EVENTS;
    end else begin
      nxt_irq = IRQ_EVENTS;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_ff <= 8'h00;
      int_ff <= 1'b0;
    end else if (clr_all) begin
      irq_ff <= 8'h00;
      int_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
      int_ff <= |nxt_irq;
    end
  end

  assign POWER_ON = power_ff;
  assign THREE_WIRE = three_wire_ff;
  assign OP_MODE = mode_ff[MODE_OP_LSB +: 2];
  assign OUTPUT_RATE = mode_ff[MODE_RATE_LSB +: 3];
  assign ADV_SELFTEST = mode_ff[MODE_ADV_LSB +: 2];
  assign SELFTEST_TRIG = mode_ff[MODE_SELFTEST_BIT];
  assign SOFT_RESET_DONE = sr_done_ff;
  assign POR_PULSE = por_ff;
  assign INT_OUT = int_ff;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  AST_Z_LOW: assert property (SAMPLE_VALID && power_ff && !clr_all |=>
    (reg_value(ADDR_Z_LOW) & 8'hfe) == {$past(Z_SAMPLE[6:0]), 1'b0}) else $error("z low bits wrong");
  AST_Z_ST_DEFAULT: assert property (sr_done |=> (reg_value(ADDR_Z_LOW) & 8'h01) == 8'h01)
    else $error("z self-test flag not one after reset");
  AST_Z_HIGH: assert property (SAMPLE_VALID && power_ff && !clr_all |=>
    reg_value(ADDR_Z_HIGH) == $past(Z_SAMPLE[14:7])) else $error("z high bits wrong");
  AST_HALL_LOW: assert property (SAMPLE_VALID && power_ff && !clr_all |=>
    (reg_value(ADDR_HALL_LOW) & 8'hfe) == {$past(HALL_SAMPLE[5:0]), 2'b00}) else $error("hall low wrong");
  AST_HALL_HIGH: assert property (SAMPLE_VALID && power_ff && !clr_all |=>
    reg_value(ADDR_HALL_HIGH) == $past(HALL_SAMPLE[13:6])) else $error("hall high wrong");
  AST_READY: assert property (SAMPLE_VALID && power_ff && !clr_all |=>
    (reg_value(ADDR_HALL_LOW) & 8'h01) == 8'h01) else $error("ready bit not set");
  AST_SUSPEND_CLOSED: assert property (!power_ff |->
    reg_value(ADDR_MODE) == 8'h00 && reg_value(ADDR_CHIP_ID) == 8'h00) else $error("register open in suspend");
  AST_SRST_CAUSE: assert property ($rose(sr_state_ff == SR_RUN) |->
    $past(wr_power && rx_byte[SRST_HI_BIT] && rx_byte[SRST_LO_BIT])) else $error("soft reset without both bits");
  AST_SRST_KEEPS_POWER: assert property (sr_done |=> power_ff && $stable(three_wire_ff))
    else $error("soft reset disturbed power register");
  AST_SRST_SLEEP: assert property (sr_done |=> OP_MODE == OPMODE_SLEEP)
    else $error("soft reset did not enter sleep");
  AST_SRST_SUSPEND: assert property (!power_ff && sr_state_ff == SR_IDLE |=>
    sr_state_ff == SR_IDLE) else $error("soft reset ran in suspend");
  AST_SRST_SELFCLR: assert property ($rose(sr_state_ff == SR_RUN) |->
    ##4 ((!srst_hi_ff && !srst_lo_ff) || wr_power)) else $error("trigger bits not cleared");
  AST_POR: assert property (por_go |=> POR_PULSE ##1 !POR_PULSE)
    else $error("power-on pulse missing");
  AST_WIRE_SEL: assert property (!(SDO_OE && SDX_OE) && (SDX_OE -> THREE_WIRE))
    else $error("both data outputs driven");
  AST_PWR_RSVD: assert property ((reg_value(ADDR_POWER) & 8'h78) == 8'h00)
    else $error("power register reserved bits set");
  AST_LATCH_HOLD: assert property (INT_LATCH && INT_OUT && !irq_read && !clr_all |=> INT_OUT)
    else $error("latched interrupt dropped without read");
  AST_RO_IRQ: assert property (wr_en && addr_ff == ADDR_IRQ_FLAGS && INT_LATCH && IRQ_EVENTS == 8'h00
    && !clr_all && !irq_read |=> $stable(irq_ff)) else $error("host write changed irq flags");

  COV_SOFT_RESET: cover property (sr_start ##[1:8] sr_done);
  COV_POR: cover property (por_go);
  COV_READ_3W: cover property (SDX_OE ##1 SDX_OE);
  COV_IRQ_CLEAR: cover property (INT_LATCH && INT_OUT ##1 irq_read);
endmodule

//--- dv/mg_spi_host.sv
// host side of the serial register link, spi mode 0, msb first
// assumes the bench routes MISO from the pin that is live in the selected wire mode
`timescale 1ns/1ps
module mg_spi_host (
  input wire logic MCLK,
  output logic CSB,
  output logic SCK,
  output logic SDI_H,
  input wire logic MISO
);
  // half period of six core cycles keeps the device's pin sampler comfortably ahead
  localparam int HALF = 6;
  initial begin
    CSB = 1'b1;
    SCK = 1'b0;
    SDI_H = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  // in a read byte the host keeps driving the data line and toggles its level on every bit
  task automatic byte_io(input logic [7:0] tx, input logic rd_ph, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      SDI_H = rd_ph ? ~SDI_H : tx[i];
      tick(HALF);
      SCK = 1'b1;
      rx[i] = MISO;
      tick(HALF);
      SCK = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] junk;
    CSB = 1'b0;
    tick(HALF);
    byte_io(hdr, 1'b0, junk);
    byte_io(wd, hdr[7], rd);
    tick(HALF);
    CSB = 1'b1;
    tick(HALF);
  endtask
endmodule

//--- dv/mg_regbank_tb.sv
// self-checking bench for the magnetometer register bank
// assumes the host model above drives the serial pins; sensor inputs come from here
`timescale 1ns/1ps
module mg_regbank_tb;
  import mg_pkg::*;
  localparam logic [7:0] CID = 8'h6c; // arbitrary identification value
  logic MCLK = 1'b0;
  logic RST_B, SAMPLE_VALID, Z_ST_RESULT, INT_LATCH, tw;
  logic [14:0] z;
  logic [13:0] h;
  logic [7:0] IRQ_EVENTS, v;
  logic csb, sck, sdi_h, sdo_o, sdo_oe, sdx_o, sdx_oe, sdi_line, miso;
  logic power_on, three_wire, sel_trig, srst_done, por_pulse, int_out;
  logic [1:0] op_mode, adv;
  logic [2:0] rate;
  logic [1:0] op_tab [3] = '{OPMODE_NORMAL, OPMODE_FORCED, OPMODE_SLEEP};
  int n_errors = 0;
  int tests_run = 0;
  int n_por = 0;
  int n_srst = 0;
  int cycles = 0;
  always #12.5 MCLK = ~MCLK;
  assign sdi_line = sdx_oe ? sdx_o : sdi_h;
  assign miso = tw ? sdi_line : (sdo_oe ? sdo_o : sdi_h);
  mg_spi_host u_host (.MCLK(MCLK), .CSB(csb), .SCK(sck), .SDI_H(sdi_h), .MISO(miso));
  mg_regbank #(.CHIP_ID(CID)) u_dut (
    .MCLK(MCLK), .RST_B(RST_B), .CSB(csb), .SCK(sck), .SDI(sdi_line),
    .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SDX_O(sdx_o), .SDX_OE(sdx_oe),
    .Z_SAMPLE(z), .Z_ST_RESULT(Z_ST_RESULT), .HALL_SAMPLE(h), .SAMPLE_VALID(SAMPLE_VALID),
    .IRQ_EVENTS(IRQ_EVENTS), .INT_LATCH(INT_LATCH), .POWER_ON(power_on), .THREE_WIRE(three_wire),
    .OP_MODE(op_mode), .OUTPUT_RATE(rate), .ADV_SELFTEST(adv), .SELFTEST_TRIG(sel_trig),
    .SOFT_RESET_DONE(srst_done), .POR_PULSE(por_pulse), .INT_OUT(int_out));
  function automatic logic [7:0] zlo(input logic [14:0] s, input logic st);
    return {s[6:0], st};
  endfunction
  function automatic logic [7:0] hlo(input logic [13:0] s, input logic rdy);
    return {s[5:0], 1'b0, rdy};
  endfunction
  task automatic results();
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp(got, exp);
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    cmp(got, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.frame({1'b0, a}, d, r);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    u_host.frame({1'b1, a}, 8'h00, r);
    chk_reg(r, e);
  endtask
  task automatic sample(input logic [14:0] zs, input logic [13:0] hs, input logic st);
    z = zs;
    h = hs;
    Z_ST_RESULT = st;
    SAMPLE_VALID = 1'b1;
    tick(1);
    SAMPLE_VALID = 1'b0;
    tick(2);
  endtask
  // pulses are counted here so that a missing or doubled one is seen
  always @(posedge MCLK) begin
    cycles++;
    if (por_pulse === 1'b1) n_por++;
    if (srst_done === 1'b1) n_srst++;
    if (cycles == 40000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h30b3_693b));
    RST_B = 1'b0;
    SAMPLE_VALID = 1'b0;
    Z_ST_RESULT = 1'b0;
    INT_LATCH = 1'b1;
    IRQ_EVENTS = 8'h00;
    z = '0;
    h = '0;
    tw = 1'b0;
    tick(16);
    RST_B = 1'b1;
    tick(4);
    chk_pin({power_on, three_wire, op_mode, rate, int_out}, {2'b00, OPMODE_SLEEP, RATE_10HZ, 1'b0});
    rd(ADDR_POWER, 8'h00);
    rd(ADDR_CHIP_ID, 8'h00);
    wr(ADDR_MODE, 8'h38);
    rd(ADDR_MODE, 8'h00);
    wr(ADDR_POWER, 8'h79);
    chk_pin(8'(n_por), 8'h01);
    chk_pin(8'(power_on), 8'h01);
    rd(ADDR_POWER, 8'h01);
    rd(ADDR_MODE, MODE_RST);
    rd(ADDR_CHIP_ID, CID);
    for (int i = 0; i < 4; i++) begin
      logic [14:0] zs;
      logic [13:0] hs;
      logic st;
      zs = (i == 0) ? 15'h7fff : 15'($urandom);
      hs = (i == 0) ? 14'h3fff : 14'($urandom);
      st = 1'($urandom);
      sample(zs, hs, st);
      rd(ADDR_Z_LOW, zlo(zs, st));
      rd(ADDR_Z_HIGH, zs[14:7]);
      rd(ADDR_HALL_LOW, hlo(hs, 1'b1));
      rd(ADDR_HALL_HIGH, hs[13:6]);
      rd(ADDR_HALL_LOW, hlo(hs, 1'b0));
    end
    wr(ADDR_Z_HIGH, ~z[14:7]);
    rd(ADDR_Z_HIGH, z[14:7]);
    wr(ADDR_IRQ_FLAGS, 8'hff);
    rd(ADDR_IRQ_FLAGS, 8'h00);
    for (int r = 0; r < 8; r++) begin
      logic [1:0] op;
      logic [7:0] d;
      op = op_tab[r % 3];
      d = {2'($urandom), 3'(r), op, 1'($urandom)};
      wr(ADDR_MODE, d);
      chk_pin(8'(rate), 8'(r));
      chk_pin(8'(op_mode), 8'(op));
      chk_pin(8'({adv, sel_trig}), 8'({d[7:6], d[0]}));
      rd(ADDR_MODE, d);
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h80 : 8'($urandom) | 8'h01;
      IRQ_EVENTS = v;
      tick(1);
      IRQ_EVENTS = 8'h00;
      tick(3);
      chk_pin(8'(int_out), 8'h01);
      rd(ADDR_HALL_HIGH, h[13:6]);
      chk_pin(8'(int_out), 8'h01);
      rd(ADDR_IRQ_FLAGS, v);
      chk_pin(8'(int_out), 8'h00);
      rd(ADDR_IRQ_FLAGS, 8'h00);
    end
    INT_LATCH = 1'b0;
    v = 8'($urandom) | 8'h40;
    IRQ_EVENTS = v;
    tick(3);
    rd(ADDR_IRQ_FLAGS, v);
    chk_pin(8'(int_out), 8'h01);
    IRQ_EVENTS = 8'h00;
    tick(3);
    chk_pin(8'(int_out), 8'h00);
    INT_LATCH = 1'b1;
    wr(ADDR_POWER, 8'h81);
    tick(8);
    chk_pin(8'(n_srst), 8'h00);
    wr(ADDR_POWER, 8'h83);
    tick(8);
    chk_pin(8'(n_srst), 8'h01);
    chk_pin({power_on, op_mode}, {1'b1, OPMODE_SLEEP});
    rd(ADDR_POWER, 8'h01);
    rd(ADDR_MODE, MODE_RST);
    rd(ADDR_Z_LOW, 8'h01);
    rd(ADDR_HALL_LOW, 8'h00);
    wr(ADDR_POWER, 8'h05);
    chk_pin(8'(three_wire), 8'h01);
    tw = 1'b1;
    rd(ADDR_POWER, 8'h05);
    wr(ADDR_MODE, 8'h5b);
    rd(ADDR_MODE, 8'h5b);
    wr(ADDR_POWER, 8'h01);
    tw = 1'b0;
    chk_pin(8'(three_wire), 8'h00);
    wr(ADDR_POWER, 8'h00);
    chk_pin(8'(power_on), 8'h00);
    rd(ADDR_MODE, 8'h00);
    wr(ADDR_POWER, 8'h82);
    tick(8);
    chk_pin(8'(n_srst), 8'h01);
    rd(ADDR_POWER, 8'h00);
    wr(ADDR_POWER, 8'h01);
    chk_pin(8'(n_por), 8'h02);
    rd(ADDR_MODE, MODE_RST);
    results();
  end
endmodule
